// file: design/gpio_ports_pkg.sv
// Purpose: shared constants for the parallel port block (ports B to E)
// Assumes: 8-bit register port, byte offsets as listed below
// Notes:   data latches have no reset value; direction and control do

package gpio_ports_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int PIN_W  = 32;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_PORT_B_DATA      = 5'h01;
  localparam logic [4:0] ADDR_PORT_C_DATA      = 5'h02;
  localparam logic [4:0] ADDR_PORT_D_DATA      = 5'h03;
  localparam logic [4:0] ADDR_PORT_B_DIRECTION = 5'h05;
  localparam logic [4:0] ADDR_PORT_C_DIRECTION = 5'h06;
  localparam logic [4:0] ADDR_PORT_D_DIRECTION = 5'h07;
  localparam logic [4:0] ADDR_PORT_E_DATA      = 5'h08;
  localparam logic [4:0] ADDR_PORT_E_DIRECTION = 5'h0C;
  localparam logic [4:0] ADDR_KEY_IRQ_CONTROL  = 5'h10;
  localparam logic [4:0] ADDR_EDGE_LEVEL       = 5'h11;
  localparam logic [4:0] ADDR_SHARE_CONTROL    = 5'h12;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [7:0] READ_IDLE       = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PRESCALER_LSB  = 0;
  localparam int SERIAL_EN_BIT  = 3;
  localparam logic [2:0] PRESCALER_EXT_CLK = 3'h7;
  localparam int RX_PIN_BIT     = 1;
  localparam int TX_PIN_BIT     = 2;
  localparam int EXT_CLOCK_PIN  = 3;
  localparam int TIMER_PIN_LSB  = 4;
  localparam int PIN_B_LSB      = 0;
  localparam int PIN_C_LSB      = 8;
  localparam int PIN_D_LSB      = 16;
  localparam int PIN_E_LSB      = 24;

endpackage

// file: design/parallel_ports_b_to_e.sv
// Purpose: parallel ports B, C, D and E with data latches and direction
// Assumes: single 250 MHz clock, sync active-high reset, pins async
// Notes:   port E pins may be lent to the timer and the serial unit
//
// How it works
// - direction bit one drives the pin; zero leaves it high-impedance input.
// - reset clears port B, C and D direction registers to all inputs.
// - reset leaves the port C and D data latches unchanged.
// - a data write always updates the latch whatever the direction.
// - writing an input pin changes only the latch, not the read level.
// - key irq enable bits route port D pins as interrupt inputs.
// - port E is eight bits, five shared with timer, two with serial.
// - port E bits 7..4 are timer channels when edge/level field nonzero.
// - a lent port E pin ignores its direction bit for drive.
// - the port E direction bit still picks latch or pin on reads.
// - port E bit 3 feeds timer external clock when prescaler selects it.
// - port E bit 2 carries serial transmit while serial is enabled.
// - port E bit 1 feeds serial receive while serial is enabled.
// - reset leaves the port B data latches unchanged.
//
// Decided for this implementation: the plain strobed port.

`timescale 1ns/1ps
`default_nettype none

module parallel_ports_b_to_e
  import gpio_ports_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic [gpio_ports_pkg::ADDR_W-1:0] addr,
  input  wire logic [gpio_ports_pkg::DATA_W-1:0] wr_data,
  input  wire logic                          wr_stb,
  input  wire logic                          rd_stb,
  output logic      [gpio_ports_pkg::DATA_W-1:0] rd_data,
  input  wire logic [7:0]                    pb_in,
  output logic      [7:0]                    pb_out,
  output logic      [7:0]                    pb_oe,
  input  wire logic [7:0]                    pc_in,
  output logic      [7:0]                    pc_out,
  output logic      [7:0]                    pc_oe,
  input  wire logic [7:0]                    pd_in,
  output logic      [7:0]                    pd_out,
  output logic      [7:0]                    pd_oe,
  input  wire logic [7:0]                    pe_in,
  output logic      [7:0]                    pe_out,
  output logic      [7:0]                    pe_oe,
  output logic      [7:0]                    key_irq_pins,
  input  wire logic [3:0]                    timer_ch_out,
  input  wire logic [3:0]                    timer_ch_oe,
  output logic      [3:0]                    timer_ch_in,
  output logic                               timer_external_clock,
  input  wire logic                          serial_tx,
  output logic                               serial_rx
);

  import gpio_ports_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // per-bit choice between the latch and the sampled pin
  function automatic logic [7:0] read_mix(
    input logic [7:0] dir,
    input logic [7:0] latch,
    input logic [7:0] pin
  );
    read_mix = (dir & latch) | (~dir & pin);
  endfunction

  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] target
  );
    hit = (a == target);
  endfunction

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  // three stages; a level is taken only once stages two and three agree,
  // which costs a cycle but rejects single-sample glitches
  logic [PIN_W-1:0] sync_1;
  logic [PIN_W-1:0] sync_2;
  logic [PIN_W-1:0] sync_3;
  logic [PIN_W-1:0] pin_level;
  logic [PIN_W-1:0] next_pin_level;
  logic [PIN_W-1:0] stage_differ;

  always_comb begin
    stage_differ   = sync_2 ^ sync_3;
    next_pin_level = (sync_3 & ~stage_differ) | (pin_level & stage_differ);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_1    <= '0;
      sync_2    <= '0;
      sync_3    <= '0;
      pin_level <= '0;
    end else begin
      sync_1    <= {pe_in, pd_in, pc_in, pb_in};
      sync_2    <= sync_1;
      sync_3    <= sync_2;
      pin_level <= next_pin_level;
    end
  end

  logic [7:0] pin_b;
  logic [7:0] pin_c;
  logic [7:0] pin_d;
  logic [7:0] pin_e;

  always_comb begin
    pin_b = pin_level[PIN_B_LSB +: 8];
    pin_c = pin_level[PIN_C_LSB +: 8];
    pin_d = pin_level[PIN_D_LSB +: 8];
    pin_e = pin_level[PIN_E_LSB +: 8];
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_b_data;
  logic wr_c_data;
  logic wr_d_data;
  logic wr_e_data;
  logic wr_b_dir;
  logic wr_c_dir;
  logic wr_d_dir;
  logic wr_e_dir;
  logic wr_key;
  logic wr_edge;
  logic wr_share;

  always_comb begin
    wr_b_data = wr_stb && hit(addr, ADDR_PORT_B_DATA);
    wr_c_data = wr_stb && hit(addr, ADDR_PORT_C_DATA);
    wr_d_data = wr_stb && hit(addr, ADDR_PORT_D_DATA);
    wr_e_data = wr_stb && hit(addr, ADDR_PORT_E_DATA);
    wr_b_dir  = wr_stb && hit(addr, ADDR_PORT_B_DIRECTION);
    wr_c_dir  = wr_stb && hit(addr, ADDR_PORT_C_DIRECTION);
    wr_d_dir  = wr_stb && hit(addr, ADDR_PORT_D_DIRECTION);
    wr_e_dir  = wr_stb && hit(addr, ADDR_PORT_E_DIRECTION);
    wr_key    = wr_stb && hit(addr, ADDR_KEY_IRQ_CONTROL);
    wr_edge   = wr_stb && hit(addr, ADDR_EDGE_LEVEL);
    wr_share  = wr_stb && hit(addr, ADDR_SHARE_CONTROL);
  end

  // ----------------------------------------------------------------
  // data latches
  // ----------------------------------------------------------------
  // no reset on purpose: contents survive a system reset
  logic [7:0] port_b_data;
  logic [7:0] port_c_data;
  logic [7:0] port_d_data;
  logic [7:0] port_e_data;
  logic [7:0] next_port_b_data;
  logic [7:0] next_port_c_data;
  logic [7:0] next_port_d_data;
  logic [7:0] next_port_e_data;

  always_comb begin
    next_port_b_data = wr_b_data ? wr_data : port_b_data;
    next_port_c_data = wr_c_data ? wr_data : port_c_data;
    next_port_d_data = wr_d_data ? wr_data : port_d_data;
    next_port_e_data = wr_e_data ? wr_data : port_e_data;
  end

  always_ff @(posedge clk) begin
    port_b_data <= next_port_b_data;
    port_c_data <= next_port_c_data;
    port_d_data <= next_port_d_data;
    port_e_data <= next_port_e_data;
  end

  // ----------------------------------------------------------------
  // direction and control registers
  // ----------------------------------------------------------------
  logic [7:0] port_b_direction;
  logic [7:0] port_c_direction;
  logic [7:0] port_d_direction;
  logic [7:0] port_e_direction;
  logic [7:0] key_irq_control;
  logic [7:0] edge_level_select;
  logic [7:0] share_control;
  logic [7:0] next_port_b_direction;
  logic [7:0] next_port_c_direction;
  logic [7:0] next_port_d_direction;
  logic [7:0] next_port_e_direction;
  logic [7:0] next_key_irq_control;
  logic [7:0] next_edge_level_select;
  logic [7:0] next_share_control;

  always_comb begin
    next_port_b_direction  = wr_b_dir ? wr_data : port_b_direction;
    next_port_c_direction  = wr_c_dir ? wr_data : port_c_direction;
    next_port_d_direction  = wr_d_dir ? wr_data : port_d_direction;
    next_port_e_direction  = wr_e_dir ? wr_data : port_e_direction;
    next_key_irq_control   = wr_key   ? wr_data : key_irq_control;
    next_edge_level_select = wr_edge  ? wr_data : edge_level_select;
    next_share_control     = wr_share ? wr_data : share_control;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_b_direction  <= DIRECTION_RESET;
      port_c_direction  <= DIRECTION_RESET;
      port_d_direction  <= DIRECTION_RESET;
      port_e_direction  <= DIRECTION_RESET;
      key_irq_control   <= CONTROL_RESET;
      edge_level_select <= CONTROL_RESET;
      share_control     <= CONTROL_RESET;
    end else begin
      port_b_direction  <= next_port_b_direction;
      port_c_direction  <= next_port_c_direction;
      port_d_direction  <= next_port_d_direction;
      port_e_direction  <= next_port_e_direction;
      key_irq_control   <= next_key_irq_control;
      edge_level_select <= next_edge_level_select;
      share_control     <= next_share_control;
    end
  end

  // ----------------------------------------------------------------
  // port E sharing
  // ----------------------------------------------------------------
  logic [3:0] timer_owns;
  logic       ext_clock_sel;
  logic       serial_en;

  always_comb begin
    for (int ch = 0; ch < 4; ch++) begin
      timer_owns[ch] = |edge_level_select[2*ch +: 2];
    end
    ext_clock_sel = share_control[PRESCALER_LSB +: 3] == PRESCALER_EXT_CLK;
    serial_en     = share_control[SERIAL_EN_BIT];
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // port E drive is registered, so lent pins follow the timer and the
  // serial unit one cycle late; that keeps every data output on a flop
  logic [7:0] next_pe_out;
  logic [7:0] next_pe_oe;
  logic [7:0] next_key_irq_pins;
  logic [3:0] next_timer_ch_in;
  logic       next_timer_external_clock;
  logic       next_serial_rx;

  always_comb begin
    next_pe_out = port_e_data;
    next_pe_oe  = port_e_direction;
    for (int ch = 0; ch < 4; ch++) begin
      if (timer_owns[ch]) begin
        next_pe_out[TIMER_PIN_LSB + ch] = timer_ch_out[ch];
        next_pe_oe[TIMER_PIN_LSB + ch]  = timer_ch_oe[ch];
      end
    end
    if (ext_clock_sel) begin
      next_pe_oe[EXT_CLOCK_PIN] = 1'b0;
    end
    if (serial_en) begin
      next_pe_out[TX_PIN_BIT] = serial_tx;
      next_pe_oe[TX_PIN_BIT]  = 1'b1;
      next_pe_oe[RX_PIN_BIT]  = 1'b0;
    end
    next_key_irq_pins = pin_d & key_irq_control;
    next_timer_ch_in  = pin_e[TIMER_PIN_LSB +: 4] & timer_owns;
    next_timer_external_clock = ext_clock_sel & pin_e[EXT_CLOCK_PIN];
    // receive idles high while the serial unit is off
    next_serial_rx = serial_en ? pin_e[RX_PIN_BIT] : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pe_out               <= '0;
      pe_oe                <= DIRECTION_RESET;
      key_irq_pins         <= '0;
      timer_ch_in          <= '0;
      timer_external_clock <= 1'b0;
      serial_rx            <= 1'b1;
    end else begin
      pe_out               <= next_pe_out;
      pe_oe                <= next_pe_oe;
      key_irq_pins         <= next_key_irq_pins;
      timer_ch_in          <= next_timer_ch_in;
      timer_external_clock <= next_timer_external_clock;
      serial_rx            <= next_serial_rx;
    end
  end

  always_comb begin
    pb_out = port_b_data;
    pc_out = port_c_data;
    pd_out = port_d_data;
    pb_oe  = port_b_direction;
    pc_oe  = port_c_direction;
    pd_oe  = port_d_direction;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // data stand only in the cycle after the strobe; otherwise zero
  logic [7:0] read_value;
  logic [7:0] next_rd_data;

  always_comb begin
    case (addr)
      ADDR_PORT_B_DATA:
        read_value = read_mix(port_b_direction, port_b_data, pin_b);
      ADDR_PORT_C_DATA:
        read_value = read_mix(port_c_direction, port_c_data, pin_c);
      ADDR_PORT_D_DATA:
        read_value = read_mix(port_d_direction, port_d_data, pin_d);
      ADDR_PORT_E_DATA:
        read_value = read_mix(port_e_direction, port_e_data, pin_e);
      ADDR_PORT_B_DIRECTION: read_value = port_b_direction;
      ADDR_PORT_C_DIRECTION: read_value = port_c_direction;
      ADDR_PORT_D_DIRECTION: read_value = port_d_direction;
      ADDR_PORT_E_DIRECTION: read_value = port_e_direction;
      ADDR_KEY_IRQ_CONTROL:  read_value = key_irq_control;
      ADDR_EDGE_LEVEL:       read_value = edge_level_select;
      ADDR_SHARE_CONTROL:    read_value = share_control;
      default:               read_value = READ_IDLE;
    endcase
    next_rd_data = rd_stb ? read_value : READ_IDLE;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= READ_IDLE;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule

`default_nettype wire

// file: dv/pin_board_model.sv
// Purpose: board side of the port pins
// Assumes: every pin has a resistor to a level the bench sets
// Notes:   a released pin shows the board level, never the old drive
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] pc_out,
  input  wire logic [7:0] pc_oe,
  input  wire logic [7:0] pd_out,
  input  wire logic [7:0] pd_oe,
  input  wire logic [7:0] pe_out,
  input  wire logic [7:0] pe_oe,
  input  wire logic [7:0] ext_b,
  input  wire logic [7:0] ext_c,
  input  wire logic [7:0] ext_d,
  input  wire logic [7:0] ext_e,
  output logic      [7:0] pb_in,
  output logic      [7:0] pc_in,
  output logic      [7:0] pd_in,
  output logic      [7:0] pe_in
);
  // ------------------------------------------------------------
  // wire level: driver wins, else board level
  // ------------------------------------------------------------
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
  assign pd_in = (pd_oe & pd_out) | (~pd_oe & ext_d);
  assign pe_in = (pe_oe & pe_out) | (~pe_oe & ext_e);
endmodule
`default_nettype wire

// file: dv/parallel_ports_b_to_e_monitor.sv
// Purpose: port checker for the parallel port block
// Assumes: one clock, synchronous active-high reset
// Notes:   helpers shadow control writes the ports do not show
`timescale 1ns/1ps
`default_nettype none
module parallel_ports_b_to_e_monitor
  import gpio_ports_pkg::*;
(
  input wire logic                               clk,
  input wire logic                               sys_rst,
  input wire logic [gpio_ports_pkg::ADDR_W-1:0]  addr,
  input wire logic [gpio_ports_pkg::DATA_W-1:0]  wr_data,
  input wire logic                               wr_stb,
  input wire logic                               rd_stb,
  input wire logic [gpio_ports_pkg::DATA_W-1:0]  rd_data,
  input wire logic [7:0]                         pb_out,
  input wire logic [7:0]                         pb_oe,
  input wire logic [7:0]                         pc_out,
  input wire logic [7:0]                         pc_oe,
  input wire logic [7:0]                         pd_oe,
  input wire logic [7:0]                         pe_out,
  input wire logic [7:0]                         pe_oe,
  input wire logic [7:0]                         key_irq_pins,
  input wire logic                               serial_tx,
  input wire logic                               serial_rx
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic       ser_en = 1'b0;
  logic [7:0] kie    = 8'h00;
  logic       b_seen = 1'b0;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ser_en <= 1'b0;
      kie    <= 8'h00;
    end else if (wr_stb && addr == ADDR_SHARE_CONTROL) begin
      ser_en <= wr_data[SERIAL_EN_BIT];
    end else if (wr_stb && addr == ADDR_KEY_IRQ_CONTROL) begin
      kie    <= wr_data;
    end
  end
  // latch is unknown until written, so hold checks wait for a write
  always_ff @(posedge clk) begin
    if (wr_stb && addr == ADDR_PORT_B_DATA) begin
      b_seen <= 1'b1;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_dir_reset: assert property (disable iff (1'b0) sys_rst |=>
    (pb_oe | pc_oe | pd_oe) == DIRECTION_RESET) else $error("direction not cleared");
  chk_latch_keep: assert property (disable iff (1'b0)
    sys_rst && b_seen && !wr_stb |=> pb_out == $past(pb_out)) else $error("latch lost");
  chk_dir_write: assert property (wr_stb && addr == ADDR_PORT_B_DIRECTION |=>
    pb_oe == $past(wr_data)) else $error("drive enable wrong");
  chk_latch_write: assert property (wr_stb && addr == ADDR_PORT_C_DATA |=>
    pc_out == $past(wr_data)) else $error("latch not written");
  chk_read_idle: assert property (!rd_stb |=> rd_data == READ_IDLE)
    else $error("read data outside slot");
  chk_read_latch: assert property (rd_stb && addr == ADDR_PORT_B_DATA && pb_oe == 8'hFF
    |=> rd_data == $past(pb_out)) else $error("output read not latch");
  chk_tx_share: assert property (ser_en && $past(ser_en) |->
    pe_oe[2] && pe_out[2] == $past(serial_tx)) else $error("transmit not on pin");
  chk_rx_idle: assert property (!ser_en && !$past(ser_en) |-> serial_rx)
    else $error("receive not idle");
  chk_key_mask: assert property ((key_irq_pins & ~$past(kie)) == 8'h00)
    else $error("masked key pin active");
  cover property (rd_stb && addr == ADDR_PORT_E_DATA);
  cover property (ser_en && pe_oe[2]);
  cover property (key_irq_pins != 8'h00);
endmodule
bind parallel_ports_b_to_e parallel_ports_b_to_e_monitor parallel_ports_b_to_e_monitor_i (
  .clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_data(rd_data), .pb_out(pb_out), .pb_oe(pb_oe), .pc_out(pc_out),
  .pc_oe(pc_oe), .pd_oe(pd_oe), .pe_out(pe_out), .pe_oe(pe_oe),
  .key_irq_pins(key_irq_pins), .serial_tx(serial_tx), .serial_rx(serial_rx));
`default_nettype wire

// file: dv/tb_parallel_ports_b_to_e.sv
// Purpose: self-checking bench for the parallel port block
// Assumes: 250 MHz clock, reset held 8 cycles
// Notes:   waits of 6 cycles cover the pin filter; port E adds its drive flop
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_ports_b_to_e;
  import gpio_ports_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic       clk = 1'b0, sys_rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wr_data = 8'h00, rd_data, pb_in, pc_in, pd_in, pe_in;
  logic [7:0] pb_out, pb_oe, pc_out, pc_oe, pd_out, pd_oe, pe_out, pe_oe, key_irq_pins;
  logic [7:0] ext_bc = 8'hA5, ext_d = 8'hA5, ext_e = 8'h00;
  logic [3:0] timer_ch_out = 4'h0, timer_ch_oe = 4'h0, timer_ch_in;
  logic       timer_external_clock, serial_tx = 1'b0, serial_rx;
  int         n_fail = 0, checked = 0, cyc = 0;
  logic [4:0] dat_a [3] = '{ADDR_PORT_B_DATA, ADDR_PORT_C_DATA, ADDR_PORT_D_DATA};
  logic [4:0] dir_a [3] = '{ADDR_PORT_B_DIRECTION, ADDR_PORT_C_DIRECTION,
                           ADDR_PORT_D_DIRECTION};
  always #2 clk = ~clk;
  parallel_ports_b_to_e parallel_ports_b_to_e_i (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pe_in(pe_in), .pe_out(pe_out),
    .pe_oe(pe_oe), .key_irq_pins(key_irq_pins), .timer_ch_out(timer_ch_out),
    .timer_ch_oe(timer_ch_oe), .timer_ch_in(timer_ch_in),
    .timer_external_clock(timer_external_clock), .serial_tx(serial_tx), .serial_rx(serial_rx));
  pin_board_model pin_board_model_i (.pb_out(pb_out), .pb_oe(pb_oe), .pc_out(pc_out),
    .pc_oe(pc_oe), .pd_out(pd_out), .pd_oe(pd_oe), .pe_out(pe_out), .pe_oe(pe_oe),
    .ext_b(ext_bc), .ext_c(ext_bc), .ext_d(ext_d), .ext_e(ext_e), .pb_in(pb_in),
    .pc_in(pc_in), .pd_in(pd_in), .pe_in(pe_in));
  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 check(what, rd_data, exp);
  endtask
  function automatic logic [7:0] oe_of(input int p);
    return (p == 0) ? pb_oe : (p == 1) ? pc_oe : pd_oe;
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_dirs();
    for (int p = 0; p < 3; p++) begin
      rchk("dir", dir_a[p], DIRECTION_RESET);
      check("oe", oe_of(p), 8'h00);
    end
    rchk("unmapped", 5'h1F, READ_IDLE);
  endtask
  task automatic t_port_rw(input int p);
    wr(dat_a[p], 8'h3C);
    wr(dir_a[p], 8'h0F);
    repeat (6) @(posedge clk);
    check("oe", oe_of(p), 8'h0F);
    rchk("mixed", dat_a[p], 8'hAC);
    wr(dat_a[p], 8'hC3);
    rchk("input kept", dat_a[p], 8'hA3);
    wr(dir_a[p], 8'hFF);
    rchk("latch", dat_a[p], 8'hC3);
  endtask
  task automatic t_reset_latch();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      check("oe cleared", oe_of(p), DIRECTION_RESET);
      wr(dir_a[p], 8'hFF);
      rchk("latch kept", dat_a[p], 8'hC3);
    end
  endtask
  task automatic t_key_irq();
    wr(ADDR_PORT_D_DIRECTION, 8'h00);
    ext_d <= 8'hF0;
    wr(ADDR_KEY_IRQ_CONTROL, 8'h3C);
    repeat (6) @(posedge clk);
    check("key pins", key_irq_pins, 8'h30);
    rchk("d pins", ADDR_PORT_D_DATA, 8'hF0);
  endtask
  task automatic t_port_e();
    ext_e <= 8'h98;
    serial_tx <= 1'b1;
    wr(ADDR_PORT_E_DATA, 8'h5A);
    wr(ADDR_PORT_E_DIRECTION, 8'hFF);
    wr(ADDR_EDGE_LEVEL, 8'h01);
    wr(ADDR_SHARE_CONTROL, 8'h0F);
    // receive level passes drive flop, filter and output flop: wait past it
    repeat (8) @(posedge clk);
    check("e oe", pe_oe, 8'hE5);
    check("e out", pe_out & 8'hF4, 8'h44);
    check("tch in", {4'h0, timer_ch_in}, 8'h01);
    check("ext clk", {7'h00, timer_external_clock}, 8'h01);
    check("rx", {7'h00, serial_rx}, 8'h00);
    rchk("e latch", ADDR_PORT_E_DATA, 8'h5A);
    wr(ADDR_PORT_E_DIRECTION, 8'h00);
    repeat (6) @(posedge clk);
    rchk("e pins", ADDR_PORT_E_DATA, 8'h9C);
    wr(ADDR_SHARE_CONTROL, 8'h00);
    repeat (6) @(posedge clk);
    check("e oe off", pe_oe, 8'h00);
    check("rx idle", {7'h00, serial_rx}, 8'h01);
    check("clk off", {7'h00, timer_external_clock}, 8'h00);
  endtask
  // ------------------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_dirs();
    for (int p = 0; p < 3; p++) begin
      t_port_rw(p);
    end
    t_reset_latch();
    t_key_irq();
    t_port_e();
    finish_test();
  end
endmodule
`default_nettype wire
